// ---- pkg/regport_pkg.sv ----
// shared constants for the dual mode register access port
`default_nettype none
package regport_pkg;
    // -----------------------------------------------------------------
    // clock and link timing
    // -----------------------------------------------------------------
    localparam int CLOCK_HZ = 50_000_000;
    localparam int TW_MAX_HZ = 400_000;
    // quarter of the fastest legal two-wire bit, rounded up
    localparam int TW_QUARTER_CYCLES =
        (CLOCK_HZ + 4 * TW_MAX_HZ - 1) / (4 * TW_MAX_HZ);
    localparam int SPI_PERIOD_NS = 160;
    localparam int SPI_HALF_CYCLES =
        (SPI_PERIOD_NS * (CLOCK_HZ / 1_000_000) + 1999) / 2000;
    // -----------------------------------------------------------------
    // frame and address layout
    // -----------------------------------------------------------------
    localparam int FRAME_BITS = 17;
    localparam int FR_RW = 16;
    localparam int FR_ADDR_LSB = 8;
    localparam logic [6:0] SLAVE_BASE = 7'h2D;
    localparam logic [7:0] DUMMY_ADDR = 8'hFF;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    localparam logic FLAG_WRITE = 1'b0;
    localparam logic FLAG_READ = 1'b1;
    // strap levels in order L, R, F, H
    localparam logic [1:0] LVL_L = 2'h0;
    localparam logic [1:0] LVL_R = 2'h1;
    localparam logic [1:0] LVL_F = 2'h2;
    localparam logic [1:0] LVL_H = 2'h3;

    // change is accepted once the 2nd and 3rd stages agree
    function automatic logic filt(input logic s2, input logic s3,
                                  input logic prev);
        return (s2 == s3) ? s3 : prev;
    endfunction
endpackage
`default_nettype wire

// ---- pkg/regport_if.sv ----
// pin level link between the register port device and its host
`default_nettype none
interface regport_if;
    logic dev_a_oe;
    logic dev_d_o;
    logic dev_d_oe;
    logic host_a_o;
    logic host_a_oe;
    logic host_b_o;
    logic host_b_oe;
    logic sel_n;
    logic line_a;
    logic line_b;
    logic line_d;
    // pull-ups set the high level of a released line
    assign line_a = !(dev_a_oe || (host_a_oe && !host_a_o));
    assign line_b = !(host_b_oe && !host_b_o);
    assign line_d = dev_d_oe ? dev_d_o : 1'b1;
    modport device (
        input line_a,
        input line_b,
        input sel_n,
        output dev_a_oe,
        output dev_d_o,
        output dev_d_oe
    );
    modport host (
        input line_a,
        input line_d,
        output host_a_o,
        output host_a_oe,
        output host_b_o,
        output host_b_oe,
        output sel_n
    );
endinterface
`default_nettype wire

// ---- hdl/regport_device.sv ----
// device end: strap-selected two-wire or four-wire register port
`default_nettype none
module regport_device
    import regport_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic [1:0] i_mode_level,
    input wire logic [1:0] i_strap_group,
    input wire logic [1:0] i_strap_member,
    input wire logic [7:0] i_rd_data,
    output logic o_spi_mode,
    output logic [6:0] o_slave_addr,
    output logic o_wr_en,
    output logic [7:0] o_acc_addr,
    output logic [7:0] o_wr_data,
    regport_if.device bus
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    localparam int DA = 0;
    localparam int CK = 1;
    localparam int SE = 2;

    typedef enum logic [2:0] {
        TW_IDLE = 3'h0,
        TW_ADDR = 3'h1,
        TW_REG = 3'h2,
        TW_DATA = 3'h3,
        TW_TX = 3'h4,
        TW_WAIT = 3'h5
    } tw_state_t;

    typedef struct packed {
        logic armed;
        logic spi;
        logic [6:0] slave;
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] f;
        tw_state_t tw;
        logic [3:0] cnt;
        logic ack;
        logic [7:0] sh;
        logic [16:0] sr;
        logic [4:0] fcnt;
        logic rd_pend;
        logic a_oe;
        logic d_o;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dev_t;

    dev_t state_reg;
    dev_t state_next;
    logic [2:0] rise;
    logic [2:0] fall;

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.wr = 1'b0;
        // pins in order: select, clock, data
        state_next.s1 = {bus.sel_n, bus.line_b, bus.line_a};
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        for (int i = 0; i < 3; i++) begin
            state_next.f[i] = filt(state_reg.s2[i], state_reg.s3[i],
                                   state_reg.f[i]);
        end
        rise = state_next.f & ~state_reg.f;
        fall = ~state_next.f & state_reg.f;

        if (!state_reg.armed) begin
            // straps are caught once after reset release
            state_next.armed = 1'b1;
            state_next.spi = (i_mode_level == LVL_F) ||
                             (i_mode_level == LVL_H);
            state_next.slave = 7'(SLAVE_BASE +
                {3'h0, i_strap_group, i_strap_member});
        end else if (state_reg.spi) begin
            // shared pins: data=serial in, clock=serial clock
            if (rise[SE]) begin
                // frames shorter than 17 clocks are dropped
                if (state_reg.fcnt == 5'(FRAME_BITS)) begin
                    state_next.addr =
                        state_reg.sr[FR_ADDR_LSB +: 8];
                    if (state_reg.sr[FR_RW] == FLAG_WRITE) begin
                        state_next.wdata = state_reg.sr[7:0];
                        state_next.wr = 1'b1;
                    end else begin
                        state_next.rd_pend = 1'b1;
                    end
                end
            end else if (fall[SE]) begin
                state_next.fcnt = 5'h0;
                state_next.d_o = state_reg.sr[FR_RW];
            end else if (!state_reg.f[SE]) begin
                if (rise[CK]) begin
                    // the register is a plain shifter so chains pass
                    state_next.sr = {state_reg.sr[15:0],
                                     state_next.f[DA]};
                    if (state_reg.fcnt != 5'(FRAME_BITS)) begin
                        state_next.fcnt = state_reg.fcnt + 5'h1;
                    end
                end
                if (fall[CK]) begin
                    state_next.d_o = state_reg.sr[FR_RW];
                end
            end
            if (state_reg.rd_pend) begin
                // read data replaces the fill byte for the next frame
                state_next.rd_pend = 1'b0;
                state_next.sr[7:0] = i_rd_data;
            end
        end else begin
            if (state_reg.f[CK] && fall[DA]) begin
                state_next.tw = TW_ADDR;
                state_next.cnt = 4'h0;
                state_next.ack = 1'b0;
                state_next.a_oe = 1'b0;
            end else if (state_reg.f[CK] && rise[DA]) begin
                state_next.tw = TW_IDLE;
                state_next.a_oe = 1'b0;
            end else if (rise[CK] && state_reg.tw != TW_IDLE &&
                         state_reg.tw != TW_WAIT &&
                         state_reg.cnt < 4'h8) begin
                state_next.cnt = state_reg.cnt + 4'h1;
                if (state_reg.tw != TW_TX) begin
                    state_next.sh = {state_reg.sh[6:0], state_next.f[DA]};
                end
            end else if (fall[CK] && state_reg.tw != TW_IDLE) begin
                if (state_reg.ack) begin
                    // end of the ninth clock: let go of the line
                    state_next.ack = 1'b0;
                    state_next.a_oe = 1'b0;
                    state_next.cnt = 4'h0;
                    if (state_reg.tw == TW_TX) begin
                        state_next.sh = i_rd_data;
                        state_next.a_oe = ~i_rd_data[7];
                    end
                end else if (state_reg.tw == TW_WAIT) begin
                    state_next.a_oe = 1'b0;
                end else if (state_reg.cnt == 4'h8) begin
                    state_next.ack = 1'b1;
                    state_next.a_oe = 1'b1;
                    case (state_reg.tw)
                        TW_ADDR: begin
                            if (state_reg.sh[7:1] == state_reg.slave) begin
                                state_next.tw = state_reg.sh[0] ? TW_TX
                                                                : TW_REG;
                            end else begin
                                state_next.tw = TW_WAIT;
                                state_next.a_oe = 1'b0;
                            end
                        end
                        TW_REG: begin
                            state_next.addr = state_reg.sh;
                            state_next.tw = TW_DATA;
                        end
                        TW_DATA: begin
                            state_next.wdata = state_reg.sh;
                            state_next.wr = 1'b1;
                            state_next.tw = TW_WAIT;
                        end
                        TW_TX: begin
                            // master answers; a single byte is served
                            state_next.a_oe = 1'b0;
                            state_next.tw = TW_WAIT;
                        end
                        default: begin
                            state_next.tw = TW_WAIT;
                        end
                    endcase
                end else if (state_reg.tw == TW_TX) begin
                    state_next.sh = {state_reg.sh[6:0], 1'b0};
                    state_next.a_oe = ~state_reg.sh[6];
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_reg <= '0;
            // start at the idle pin level so release shows no false edge
            state_reg.s1 <= 3'h7;
            state_reg.s2 <= 3'h7;
            state_reg.s3 <= 3'h7;
            state_reg.f <= 3'h7;
        end else begin
            state_reg <= state_next;
        end
    end

    // -----------------------------------------------------------------
    // pins and user side
    // -----------------------------------------------------------------
    // the serial output enable follows select with no clock delay
    assign bus.dev_d_oe = state_reg.spi & ~bus.sel_n;
    assign bus.dev_d_o = state_reg.d_o;
    assign bus.dev_a_oe = state_reg.a_oe & ~state_reg.spi;
    assign o_spi_mode = state_reg.spi;
    assign o_slave_addr = state_reg.slave;
    assign o_wr_en = state_reg.wr;
    assign o_acc_addr = state_reg.addr;
    assign o_wr_data = state_reg.wdata;
endmodule
`default_nettype wire

// ---- hdl/regport_host.sv ----
// host end: bus master for the two-wire and four-wire register port
`default_nettype none
module regport_host
    import regport_pkg::*;
#(
    parameter int CHAIN = 1,
    parameter int TW_Q = TW_QUARTER_CYCLES,
    parameter int SPI_H = SPI_HALF_CYCLES
)(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_go,
    input wire logic i_spi,
    input wire logic i_read,
    input wire logic [6:0] i_slave,
    input wire logic [7:0] i_reg,
    input wire logic [7:0] i_data,
    output logic o_busy,
    output logic o_done,
    output logic o_nack,
    output logic [7:0] o_rd_data,
    regport_if.host bus
);
    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_START = 3'h1,
        H_BYTE = 3'h2,
        H_STOP = 3'h3,
        H_SEL = 3'h4,
        H_SPI = 3'h5
    } host_state_t;

    typedef struct packed {
        host_state_t st;
        logic [1:0] q;
        logic [15:0] tick;
        logic [1:0] idx;
        logic [3:0] bitn;
        logic [11:0] bits;
        logic frame2;
        logic rd;
        logic [6:0] slave;
        logic [7:0] data;
        logic [16:0] tx;
        logic [7:0] rx;
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] f;
        logic a_o;
        logic a_oe;
        logic b_o;
        logic b_oe;
        logic sel_n;
        logic busy;
        logic done;
        logic nack;
        logic [7:0] rdat;
    } host_t;

    host_t state_reg;
    host_t state_next;
    logic step;
    logic [7:0] tb;

    // byte order: address+write, register, data or address+read, rx
    function automatic logic [7:0] byte_of(input host_t s);
        case (s.idx)
            2'h0: return {s.slave, FLAG_WRITE};
            2'h1: return s.tx[FR_ADDR_LSB +: 8];
            2'h2: return s.rd ? {s.slave, FLAG_READ} : s.data;
            default: return FILL_BYTE; // released while receiving
        endcase
    endfunction

    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.s1 = {bus.line_d, bus.line_a};
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        for (int i = 0; i < 2; i++) begin
            state_next.f[i] = filt(state_reg.s2[i], state_reg.s3[i],
                                   state_reg.f[i]);
        end
        step = 1'b0;
        tb = byte_of(state_reg);
        if (state_reg.st != H_IDLE) begin
            if (state_reg.tick == 16'((state_reg.tx[0] & 1'b0) +
                    (i_spi ? SPI_H : TW_Q) - 1)) begin
                state_next.tick = 16'h0;
                step = 1'b1;
            end else begin
                state_next.tick = state_reg.tick + 16'h1;
            end
        end
        if (step) begin
            state_next.q = state_reg.q + 2'h1;
        end
        case (state_reg.st)
            H_IDLE: begin
                if (i_go) begin
                    state_next.busy = 1'b1;
                    state_next.nack = 1'b0;
                    state_next.rd = i_read;
                    state_next.slave = i_slave;
                    state_next.data = i_data;
                    state_next.idx = 2'h0;
                    state_next.bitn = 4'h0;
                    state_next.frame2 = 1'b0;
                    state_next.q = 2'h0;
                    state_next.tick = 16'h0;
                    state_next.tx = {i_read, i_reg,
                                     i_read ? FILL_BYTE : i_data};
                    state_next.st = i_spi ? H_SEL : H_START;
                end
            end
            H_START: begin
                if (step) begin
                    case (state_reg.q)
                        2'h0: state_next.a_oe = 1'b0;
                        2'h1: state_next.b_oe = 1'b0;
                        2'h2: state_next.a_oe = 1'b1;
                        default: begin
                            state_next.b_oe = 1'b1;
                            state_next.bitn = 4'h0;
                            state_next.st = H_BYTE;
                        end
                    endcase
                end
            end
            H_BYTE: begin
                if (step) begin
                    case (state_reg.q)
                        2'h0: state_next.a_oe = (state_reg.bitn < 4'h8) ?
                            ~tb[3'(4'h7 - state_reg.bitn)] : 1'b0;
                        2'h1: state_next.b_oe = 1'b0;
                        2'h2: state_next.b_oe = 1'b0;
                        default: begin
                            state_next.b_oe = 1'b1;
                            if (state_reg.bitn != 4'h8) begin
                                state_next.rx = {state_reg.rx[6:0],
                                                 state_reg.f[0]};
                                state_next.bitn = state_reg.bitn + 4'h1;
                            end else begin
                                state_next.bitn = 4'h0;
                                state_next.idx = state_reg.idx + 2'h1;
                                if (state_reg.f[0] && state_reg.idx != 2'h3)
                                begin
                                    state_next.nack = 1'b1;
                                    state_next.st = H_STOP;
                                end else if (state_reg.idx == 2'h1 &&
                                             state_reg.rd) begin
                                    state_next.st = H_START;
                                end else if (state_reg.idx == 2'h3 ||
                                             (state_reg.idx == 2'h2 &&
                                              !state_reg.rd)) begin
                                    state_next.st = H_STOP;
                                end
                            end
                        end
                    endcase
                end
            end
            H_STOP: begin
                if (step) begin
                    case (state_reg.q)
                        2'h0: state_next.a_oe = 1'b1;
                        2'h1: state_next.b_oe = 1'b0;
                        2'h2: state_next.a_oe = 1'b0;
                        default: begin
                            state_next.st = H_IDLE;
                            state_next.busy = 1'b0;
                            state_next.done = 1'b1;
                            state_next.rdat = state_reg.rx;
                        end
                    endcase
                end
            end
            H_SEL: begin
                state_next.a_oe = 1'b1;
                state_next.b_oe = 1'b1;
                state_next.b_o = 1'b0;
                if (step && state_reg.q[0]) begin
                    state_next.sel_n = 1'b0;
                    state_next.a_o = state_reg.tx[FR_RW];
                    state_next.bits = 12'h0;
                    state_next.q = 2'h0;
                    state_next.st = H_SPI;
                end
            end
            H_SPI: begin
                if (step && !state_reg.q[0]) begin
                    state_next.b_o = 1'b1;
                end else if (step) begin
                    state_next.q = 2'h0;
                    state_next.b_o = 1'b0;
                    // the filter's fresh value: round trip fills the period
                    state_next.rx = {state_reg.rx[6:0], state_next.f[1]};
                    // rotation repeats the frame into every chained slot
                    state_next.tx = {state_reg.tx[15:0], state_reg.tx[16]};
                    state_next.a_o = state_reg.tx[15];
                    state_next.bits = state_reg.bits + 12'h1;
                    if (state_reg.bits == 12'(FRAME_BITS * CHAIN - 1))
                    begin
                        state_next.sel_n = 1'b1;
                        if (state_reg.rd && !state_reg.frame2) begin
                            state_next.frame2 = 1'b1;
                            state_next.tx = {FLAG_READ, DUMMY_ADDR,
                                             FILL_BYTE};
                            state_next.st = H_SEL;
                        end else begin
                            state_next.st = H_IDLE;
                            state_next.busy = 1'b0;
                            state_next.done = 1'b1;
                            state_next.rdat = {state_reg.rx[6:0],
                                               state_next.f[1]};
                        end
                    end
                end
            end
            default: begin
                state_next.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_reg <= '0;
            state_reg.sel_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign bus.host_a_o = state_reg.a_o;
    assign bus.host_a_oe = state_reg.a_oe;
    assign bus.host_b_o = state_reg.b_o;
    assign bus.host_b_oe = state_reg.b_oe;
    assign bus.sel_n = state_reg.sel_n;
    assign o_busy = state_reg.busy;
    assign o_done = state_reg.done;
    assign o_nack = state_reg.nack;
    assign o_rd_data = state_reg.rdat;
endmodule
`default_nettype wire

// ---- dv/regport_properties.sv ----
// concurrent checks on the pins joining host and device
`default_nettype none
module regport_properties
    import regport_pkg::*;
#(
    parameter int CHAIN = 1
)(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic dev_a_oe,
    input wire logic dev_d_oe,
    input wire logic line_a,
    input wire logic line_b,
    input wire logic sel_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);
    // counts serial clock rises while selected; cleared when deselected
    logic lb_reg;
    logic [15:0] cnt_reg;
    always_ff @(posedge i_clock) begin
        lb_reg <= line_b;
        cnt_reg <= sel_n ? 16'h0000 : cnt_reg + 16'(line_b && !lb_reg);
    end
    sequence pull_held;
        dev_a_oe[*8];
    endsequence
    chk_sel_float: assert property (sel_n |-> !dev_d_oe)
        else $error("serial out driven while deselected");
    chk_pull_low: assert property (dev_a_oe |-> !line_a)
        else $error("pulled data line not low");
    chk_oe_select: assert property ($rose(dev_d_oe) |-> $fell(sel_n))
        else $error("serial out enabled without select");
    chk_oe_release: assert property ($fell(dev_d_oe) |-> sel_n)
        else $error("serial out released while selected");
    chk_spi_quiet: assert property (!sel_n |-> !dev_a_oe)
        else $error("data line pulled in four-wire frame");
    chk_frame_len: assert property ($rose(sel_n) |->
        cnt_reg == 16'(FRAME_BITS * CHAIN))
        else $error("frame length wrong");
    chk_ack_hold: assert property ($rose(dev_a_oe) |-> pull_held)
        else $error("acknowledge pull too short");
    chk_sda_steady: assert property ($changed(dev_a_oe) |-> !line_b)
        else $error("data line moved while clock high");
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench joining the host and device ends
`default_nettype none
module tb
    import regport_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0] md;
        logic rd;
        logic [6:0] sl;
        logic [7:0] rg;
        logic [7:0] dt;
        logic nk;
    } row_t;
    // mode level, read, slave, register, data, expected nack
    localparam row_t ROWS [7] = '{
        '{2'h0, 1'b0, 7'h3C, 8'h10, 8'hA5, 1'b0},
        '{2'h0, 1'b1, 7'h3C, 8'h10, 8'hA5, 1'b0},
        '{2'h0, 1'b0, 7'h2D, 8'h11, 8'h77, 1'b1},
        '{2'h2, 1'b0, 7'h3C, 8'h20, 8'h5A, 1'b0},
        '{2'h2, 1'b1, 7'h3C, 8'h20, 8'h5A, 1'b0},
        '{2'h3, 1'b1, 7'h3C, 8'h10, 8'hA5, 1'b0},
        '{2'h1, 1'b1, 7'h3C, 8'h20, 8'h5A, 1'b0}};
    logic i_clock = 1'b0;
    logic i_srst = 1'b1;
    logic [1:0] i_mode_level = 2'h0, i_strap_group = 2'h0;
    logic [1:0] i_strap_member = 2'h0;
    logic i_go = 1'b0, i_spi = 1'b0, i_read = 1'b0;
    logic [6:0] i_slave = 7'h00, o_slave_addr;
    logic [7:0] i_reg = 8'h00, i_data = 8'h00, i_rd_data, o_acc_addr;
    logic [7:0] o_wr_data, o_rd_data;
    logic o_spi_mode, o_wr_en, o_busy, o_done, o_nack;
    logic [7:0] mem [256];
    int error_cnt = 0, comparisons = 0;
    regport_if regport_if_i ();
    regport_device regport_device_i (.i_clock, .i_srst, .i_mode_level,
        .i_strap_group, .i_strap_member, .i_rd_data, .o_spi_mode,
        .o_slave_addr, .o_wr_en, .o_acc_addr, .o_wr_data,
        .bus(regport_if_i));
    regport_host regport_host_i (.i_clock, .i_srst, .i_go, .i_spi,
        .i_read, .i_slave, .i_reg, .i_data, .o_busy, .o_done, .o_nack,
        .o_rd_data, .bus(regport_if_i));
    regport_properties regport_properties_i (.i_clock, .i_srst,
        .dev_a_oe(regport_if_i.dev_a_oe), .dev_d_oe(regport_if_i.dev_d_oe),
        .line_a(regport_if_i.line_a), .line_b(regport_if_i.line_b),
        .sel_n(regport_if_i.sel_n));
    assign i_rd_data = mem[o_acc_addr];
    always @(posedge i_clock) if (o_wr_en) mem[o_acc_addr] <= o_wr_data;
    initial forever #10 i_clock = ~i_clock;
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // straps are caught at the first edge after reset is released
    task automatic do_reset(input logic [1:0] md, input logic [3:0] k);
        i_srst = 1'b1;
        i_mode_level = md;
        {i_strap_group, i_strap_member} = k;
        tick(6);
        i_srst = 1'b0;
        tick(10);
    endtask
    task automatic run(input row_t r);
        int n;
        {i_spi, i_read, i_slave, i_reg, i_data} =
            {r.md[1], r.rd, r.sl, r.rg, r.dt};
        i_go = 1'b1;
        tick(1);
        i_go = 1'b0;
        check(8'(o_busy), 8'h01);
        for (n = 0; n < 9000 && o_done !== 1'b1; n++) tick(1);
        if (n == 9000) begin
            error_cnt++;
            close_out();
        end
        check(8'(o_nack), 8'(r.nk));
        check(8'(o_busy), 8'h00);
        // a four-wire write lands in memory five cycles after select rises with the last clock fall
        tick(8);
        if (r.rd) check(o_rd_data, r.dt);
        if (!r.rd && !r.nk) check(mem[r.rg], r.dt);
    endtask
    initial begin
        for (int k = 0; k < 16; k++) begin
            do_reset(2'h0, 4'(k));
            check(8'(o_slave_addr), 8'(7'h2D + 7'(k)));
            {i_strap_group, i_strap_member} = 4'(15 - k);
            tick(4);
            check(8'(o_slave_addr), 8'(7'h2D + 7'(k)));
        end
        for (int i = 0; i < 7; i++) begin
            if (i == 0 || ROWS[i].md != ROWS[i - 1].md) begin
                do_reset(ROWS[i].md, 4'hF);
                check(8'(o_spi_mode), 8'(ROWS[i].md[1]));
            end
            run(ROWS[i]);
        end
        close_out();
    end
endmodule
`default_nettype wire
